// [rtl/epw_deadband.sv]
`timescale 1ns/10ps
`include "epw_defs.svh"

module epw_deadband
  import epw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic raw_in,
  input wire logic [6:0] count_in,
  output logic drive_out
);

  epw_db_state_t s_r;
  epw_db_state_t s_nxt;
  logic [8:0] load;

  assign load = 9'(count_in * `EPW_TOSC_PER_TCY);

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      EPW_DB_IDLE: begin
        s_nxt.drive = 1'b0;
        if (raw_in) begin
          if (load == 9'h000) begin
            s_nxt.st = EPW_DB_ON;
            s_nxt.drive = 1'b1;
          end else begin
            s_nxt.st = EPW_DB_WAIT;
            s_nxt.cnt = load;
          end
        end
      end
      EPW_DB_WAIT: begin
        if (!raw_in) begin
          // Pulse shorter than the delay: stays inactive
          s_nxt.st = EPW_DB_IDLE;
          s_nxt.drive = 1'b0;
        end else if (s_r.cnt == 9'h001) begin
          s_nxt.st = EPW_DB_ON;
          s_nxt.drive = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 9'h001;
        end
      end
      EPW_DB_ON: begin
        if (!raw_in) begin
          s_nxt.st = EPW_DB_IDLE;
          s_nxt.drive = 1'b0;
        end
      end
      default: begin
        s_nxt.st = EPW_DB_IDLE;
        s_nxt.drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '{st: EPW_DB_IDLE, cnt: 9'h000, drive: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign drive_out = s_r.drive;

endmodule

// [rtl/epw_defs.svh]
`ifndef EPW_DEFS_SVH
`define EPW_DEFS_SVH

// Register byte offsets
`define EPW_OFF_CTRL 8'h00
`define EPW_OFF_DUTY_HIGH 8'h04
`define EPW_OFF_PERIOD 8'h08
`define EPW_OFF_DEADBAND 8'h0C
`define EPW_OFF_STEER 8'h10
`define EPW_OFF_PINDIR 8'h14
`define EPW_OFF_STATUS 8'h18
`define EPW_OFF_TIMER 8'h1C

// Control register field positions
`define EPW_CTRL_CFG_MSB 7
`define EPW_CTRL_CFG_LSB 6
`define EPW_CTRL_DLO_MSB 5
`define EPW_CTRL_DLO_LSB 4
`define EPW_CTRL_MODE_MSB 3
`define EPW_CTRL_MODE_LSB 0

// Mode bits 3:2 equal to this select PWM operation
`define EPW_MODE_PWM 2'b11
// Mode bit that inverts pins A and C, and pins B and D
`define EPW_POL_AC_BIT 1
`define EPW_POL_BD_BIT 0

// Reset values
`define EPW_RST_CTRL 8'h00
`define EPW_RST_DUTY_HIGH 8'h00
`define EPW_RST_PERIOD 8'hFF
`define EPW_RST_DEADBAND 7'h00
`define EPW_RST_STEER 4'h1
`define EPW_RST_PINDIR 4'hF

// Timing: oscillator periods per instruction cycle, clock is the oscillator
`define EPW_CLK_PERIOD_NS 4
`define EPW_TOSC_PER_TCY 4
// Oscillator phase in which the timer increments
`define EPW_PHASE_INC 2'h3

`endif

// [rtl/epw_pkg.sv]
package epw_pkg;

  typedef enum logic [1:0] {
    EPW_SINGLE = 2'b00,
    EPW_FULL_FWD = 2'b01,
    EPW_HALF = 2'b10,
    EPW_FULL_REV = 2'b11
  } epw_cfg_t;

  typedef enum logic [1:0] {
    EPW_DB_IDLE = 2'b00,
    EPW_DB_WAIT = 2'b01,
    EPW_DB_ON = 2'b10
  } epw_db_st_t;

  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] duty_lo;
    logic [3:0] mode;
  } epw_ctrl_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } epw_avm_req_t;

  typedef struct packed {
    logic enable;
    logic [7:0] period;
    logic [9:0] duty;
  } epw_tb_cfg_t;

  typedef struct packed {
    logic modulated;
    logic started;
    logic rollover;
    logic [7:0] timer;
  } epw_tb_stat_t;

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] timer;
    logic [9:0] duty_latch;
    logic modulated;
    logic started;
    logic rollover;
  } epw_tb_state_t;

  typedef struct packed {
    epw_db_st_t st;
    logic [8:0] cnt;
    logic drive;
  } epw_db_state_t;

  typedef struct packed {
    epw_ctrl_t ctrl;
    logic [7:0] duty_high;
    logic [7:0] period;
    logic [6:0] deadband;
    logic [3:0] steer;
    logic [3:0] pindir;
    logic wait_n;
    logic [31:0] rdata;
    logic [3:0] pin_level;
    logic [3:0] pin_oe_n;
    logic [3:0] pin_own;
  } epw_top_state_t;

endpackage

// [rtl/epw_timebase.sv]
`timescale 1ns/10ps
`include "epw_defs.svh"

module epw_timebase
  import epw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire epw_tb_cfg_t cfg_in,
  output epw_tb_stat_t stat_out
);

  epw_tb_state_t s_r;
  epw_tb_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rollover = 1'b0;
    if (!cfg_in.enable) begin
      s_nxt = '0;
    end else begin
      s_nxt.phase = s_r.phase + 2'h1;
      if (s_r.phase == `EPW_PHASE_INC) begin
        if (s_r.timer == cfg_in.period) begin
          s_nxt.timer = 8'h00;
          s_nxt.duty_latch = cfg_in.duty;
          s_nxt.modulated = (cfg_in.duty != 10'h000);
          s_nxt.started = 1'b1;
          s_nxt.rollover = 1'b1;
        end else begin
          s_nxt.timer = s_r.timer + 8'h01;
        end
      end
      // Ten-bit base is timer with the oscillator phase below it
      if ({s_nxt.timer, s_nxt.phase} == s_nxt.duty_latch) begin
        s_nxt.modulated = 1'b0;
      end
      // Duty above the period never matches, so the pulse stays set
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stat_out.modulated = s_r.modulated & s_r.started;
  assign stat_out.started = s_r.started;
  assign stat_out.rollover = s_r.rollover;
  assign stat_out.timer = s_r.timer;

endmodule

// [rtl/epw_top.sv]
`timescale 1ns/10ps
`include "epw_defs.svh"

// What this block does
// - A pulse-width waveform of up to ten bits of duty resolution goes out on up to four pins.
// - The output configuration field picks single, half-bridge, full forward or full reverse.
// - The mode bits choose active-high or active-low for each pin pair.
// - Writing zero to the whole control register hands every pin back to the port.
// - After enabling, no waveform appears until the first new period starts.
// - Half-bridge puts the waveform on A and its complement on B and leaves C and D unused.
// - Half-bridge delays each rise to active by the dead-band count in four-clock cycles.
// - A dead band longer than the active time keeps that half-bridge output inactive.
// - Both full-bridge modes own all four pins; each is driven only where its direction bit selects output.
// - Full forward holds A active, modulates D, and holds B and C inactive.
// - Full reverse holds C active, modulates B, and holds A and D inactive.
// - Single mode sends the waveform to whichever pins the steering bits enable.
// - Pins that the mode does not use are not driven and stay with the port.
// - At a period match the timer clears, the pulse starts unless duty is zero, duty latches.
// - The dead band delays only moves to active; moves to inactive are immediate.
module epw_top
  import epw_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] ADDRESS_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic [31:0] WRITEDATA_IN,
  input wire logic [3:0] BYTEENABLE_IN,
  output logic [31:0] READDATA_OUT,
  output logic WAITREQUEST_OUT,
  output logic [3:0] PWM_LEVEL_OUT,
  output logic [3:0] PWM_OE_N_OUT,
  output logic [3:0] PWM_OWN_OUT
);

  localparam epw_top_state_t EPW_TOP_RESET = '{
    ctrl: `EPW_RST_CTRL,
    duty_high: `EPW_RST_DUTY_HIGH,
    period: `EPW_RST_PERIOD,
    deadband: `EPW_RST_DEADBAND,
    steer: `EPW_RST_STEER,
    pindir: `EPW_RST_PINDIR,
    wait_n: 1'b0,
    rdata: 32'h0000_0000,
    pin_level: 4'h0,
    pin_oe_n: 4'hF,
    pin_own: 4'h0
  };

  epw_top_state_t s_r;
  epw_top_state_t s_nxt;

  epw_avm_req_t req;
  epw_tb_cfg_t tb_cfg;
  epw_tb_stat_t tb_stat;
  epw_cfg_t cfg;

  logic pwm_on;
  logic half_on;
  logic raw_a;
  logic raw_b;
  logic db_a;
  logic db_b;
  logic inv_ac;
  logic inv_bd;
  logic [3:0] use_mask;
  logic [3:0] act;
  logic [3:0] invert;
  logic access;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic wr_hit;
  logic wr_ctrl;
  logic wr_duty;
  logic wr_period;
  logic wr_deadband;
  logic wr_steer;
  logic wr_pindir;
  logic [3:0] out_en;
  logic [3:0] level_nxt;

  assign req.read = READ_IN;
  assign req.write = WRITE_IN;
  assign req.address = ADDRESS_IN;
  assign req.writedata = WRITEDATA_IN;
  assign req.byteenable = BYTEENABLE_IN;

  assign cfg = epw_cfg_t'(s_r.ctrl.cfg);
  assign pwm_on = (s_r.ctrl.mode[3:2] == `EPW_MODE_PWM);
  assign half_on = pwm_on && (cfg == EPW_HALF);

  assign tb_cfg.enable = pwm_on;
  assign tb_cfg.period = s_r.period;
  assign tb_cfg.duty = {s_r.duty_high, s_r.ctrl.duty_lo};

  epw_timebase u_timebase (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .cfg_in(tb_cfg),
    .stat_out(tb_stat)
  );

  // Half-bridge pair, both rises delayed by the dead band
  assign raw_a = half_on && tb_stat.started && tb_stat.modulated;
  assign raw_b = half_on && tb_stat.started && !tb_stat.modulated;

  epw_deadband u_deadband_a (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .raw_in(raw_a),
    .count_in(s_r.deadband),
    .drive_out(db_a)
  );

  epw_deadband u_deadband_b (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .raw_in(raw_b),
    .count_in(s_r.deadband),
    .drive_out(db_b)
  );

  assign inv_ac = s_r.ctrl.mode[`EPW_POL_AC_BIT];
  assign inv_bd = s_r.ctrl.mode[`EPW_POL_BD_BIT];
  assign invert = {inv_bd, inv_ac, inv_bd, inv_ac};

  // Pins used by the selected arrangement; bit 0 is A, bit 3 is D
  always_comb begin
    use_mask = 4'h0;
    if (pwm_on) begin
      case (cfg)
        EPW_SINGLE: begin
          use_mask = s_r.steer;
        end
        EPW_HALF: begin
          use_mask = 4'h3;
        end
        EPW_FULL_FWD: begin
          use_mask = 4'hF;
        end
        EPW_FULL_REV: begin
          use_mask = 4'hF;
        end
        default: begin
          use_mask = 4'h0;
        end
      endcase
    end
  end

  // Active-high view of each pin; inactive until the first period begins
  always_comb begin
    act = 4'h0;
    if (pwm_on && tb_stat.started) begin
      case (cfg)
        EPW_SINGLE: begin
          act = {4{tb_stat.modulated}} & s_r.steer;
        end
        EPW_HALF: begin
          act = {2'b00, db_b, db_a};
        end
        EPW_FULL_FWD: begin
          act = {tb_stat.modulated, 1'b0, 1'b0, 1'b1};
        end
        EPW_FULL_REV: begin
          act = {1'b0, 1'b1, tb_stat.modulated, 1'b0};
        end
        default: begin
          act = 4'h0;
        end
      endcase
    end
  end

  assign access = (req.read || req.write) && !s_r.wait_n;

  // Writes act only in the answer cycle, so a held request lands once
  assign wr_hit = s_r.wait_n && req.write && req.byteenable[0];

  // One strobe per register; read-only and unmapped offsets hit none
  always_comb begin
    wr_ctrl = 1'b0;
    wr_duty = 1'b0;
    wr_period = 1'b0;
    wr_deadband = 1'b0;
    wr_steer = 1'b0;
    wr_pindir = 1'b0;
    if (wr_hit) begin
      case (req.address)
        `EPW_OFF_CTRL: begin
          wr_ctrl = 1'b1;
        end
        `EPW_OFF_DUTY_HIGH: begin
          wr_duty = 1'b1;
        end
        `EPW_OFF_PERIOD: begin
          wr_period = 1'b1;
        end
        `EPW_OFF_DEADBAND: begin
          wr_deadband = 1'b1;
        end
        `EPW_OFF_STEER: begin
          wr_steer = 1'b1;
        end
        `EPW_OFF_PINDIR: begin
          wr_pindir = 1'b1;
        end
        default: begin
          wr_ctrl = 1'b0;
        end
      endcase
    end
  end

  // Status is taken at the request edge, so it may be one clock old
  assign status_word = {20'h00000, s_r.pin_own, s_r.pin_level, 2'b00, tb_stat.started,
                        tb_stat.modulated};

  // Pin stage: polarity applied to owned pins only
  assign level_nxt = (act ^ invert) & use_mask;
  // Driver on only where owned and direction set to output
  assign out_en = use_mask & ~s_r.pindir;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (req.address)
      `EPW_OFF_CTRL: begin
        rd_word = {24'h000000, s_r.ctrl};
      end
      `EPW_OFF_DUTY_HIGH: begin
        rd_word = {24'h000000, s_r.duty_high};
      end
      `EPW_OFF_PERIOD: begin
        rd_word = {24'h000000, s_r.period};
      end
      `EPW_OFF_DEADBAND: begin
        rd_word = {25'h0000000, s_r.deadband};
      end
      `EPW_OFF_STEER: begin
        rd_word = {28'h0000000, s_r.steer};
      end
      `EPW_OFF_PINDIR: begin
        rd_word = {28'h0000000, s_r.pindir};
      end
      `EPW_OFF_STATUS: begin
        rd_word = status_word;
      end
      `EPW_OFF_TIMER: begin
        rd_word = {24'h000000, tb_stat.timer};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // One wait cycle: request seen, then answered on the next edge
    s_nxt.wait_n = access;
    if (access && req.read) begin
      s_nxt.rdata = rd_word;
    end
    // Write lands on the edge where waitrequest is seen low
    if (wr_ctrl) begin
      s_nxt.ctrl = epw_ctrl_t'(req.writedata[7:0]);
    end
    if (wr_duty) begin
      s_nxt.duty_high = req.writedata[7:0];
    end
    if (wr_period) begin
      s_nxt.period = req.writedata[7:0];
    end
    if (wr_deadband) begin
      s_nxt.deadband = req.writedata[6:0];
    end
    if (wr_steer) begin
      s_nxt.steer = req.writedata[3:0];
    end
    if (wr_pindir) begin
      s_nxt.pindir = req.writedata[3:0];
    end
    // Released pins fall back to the port; zero control releases all
    s_nxt.pin_own = use_mask;
    s_nxt.pin_level = level_nxt;
    s_nxt.pin_oe_n = ~out_en;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      s_r <= EPW_TOP_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign READDATA_OUT = s_r.rdata;
  assign WAITREQUEST_OUT = ~s_r.wait_n;
  assign PWM_LEVEL_OUT = s_r.pin_level;
  assign PWM_OE_N_OUT = s_r.pin_oe_n;
  assign PWM_OWN_OUT = s_r.pin_own;

endmodule

// [test/epw_bridge_model.sv]
`timescale 1ns/10ps
module epw_bridge_model (
  input wire logic [3:0] level_in,
  input wire logic [3:0] oe_n_in,
  output logic [3:0] pin_out,
  output logic shoot_out
);
  // Gate driver inputs are pulled down when no driver is on
  assign pin_out = level_in & ~oe_n_in;
  // Both switches of leg A/B on together
  assign shoot_out = pin_out[0] && pin_out[1];
endmodule

// [test/epw_properties.sv]
`timescale 1ns/10ps
module epw_checker (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] ADDRESS_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic [31:0] WRITEDATA_IN,
  input wire logic [3:0] BYTEENABLE_IN,
  input wire logic WAITREQUEST_OUT,
  input wire logic [3:0] PWM_LEVEL_OUT,
  input wire logic [3:0] PWM_OE_N_OUT,
  input wire logic [3:0] PWM_OWN_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic [7:0] ctrl_r;
  logic [3:0] steer_r;
  logic [2:0] age_r;
  logic wr_ok;
  logic run;
  assign wr_ok = WRITE_IN && !WAITREQUEST_OUT && BYTEENABLE_IN[0];
  // Mode checks wait out the switch-over cycles after any write
  assign run = ctrl_r[3:2] == 2'b11 && age_r == 3'h7;
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN || wr_ok) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
    if (RESET_IN) begin
      ctrl_r <= 8'h00;
      steer_r <= 4'h1;
    end else if (wr_ok && ADDRESS_IN == 8'h00) begin
      ctrl_r <= WRITEDATA_IN[7:0];
    end else if (wr_ok && ADDRESS_IN == 8'h10) begin
      steer_r <= WRITEDATA_IN[3:0];
    end
  end
  AST_WAIT_ANS: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> !WAITREQUEST_OUT)
    else $error("bus answer late");
  AST_WAIT_ONE: assert property ($fell(WAITREQUEST_OUT) |=> $rose(WAITREQUEST_OUT))
    else $error("bus answer too long");
  AST_FREE_PINS: assert property ((PWM_OE_N_OUT | PWM_OWN_OUT) == 4'hF
    && (PWM_LEVEL_OUT & ~PWM_OWN_OUT) == 4'h0) else $error("free pin driven");
  AST_RELEASE: assert property (wr_ok && ADDRESS_IN == 8'h00 && WRITEDATA_IN[7:0] == 8'h00
    |-> ##[1:3] PWM_OWN_OUT == 4'h0) else $error("pins kept");
  AST_STEER: assert property (run && ctrl_r[7:6] == 2'b00 |-> PWM_OWN_OUT == steer_r)
    else $error("steering wrong");
  AST_HALF: assert property (run && ctrl_r[7:6] == 2'b10 |-> PWM_OWN_OUT == 4'h3
    && !((PWM_LEVEL_OUT[0] ^ ctrl_r[1]) && (PWM_LEVEL_OUT[1] ^ ctrl_r[0])))
    else $error("half bridge overlap");
  AST_FULL: assert property (run && ctrl_r[6] |-> PWM_OWN_OUT == 4'hF)
    else $error("full bridge pins");
  AST_FWD: assert property (run && ctrl_r[7:6] == 2'b01 |-> PWM_LEVEL_OUT[1] == ctrl_r[0]
    && PWM_LEVEL_OUT[2] == ctrl_r[1]) else $error("forward idle pins");
  AST_REV: assert property (run && ctrl_r[7:6] == 2'b11 |-> PWM_LEVEL_OUT[0] == ctrl_r[1]
    && PWM_LEVEL_OUT[3] == ctrl_r[0]) else $error("reverse idle pins");
endmodule
bind epw_top epw_checker chk_u (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN),
  .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN), .WRITE_IN(WRITE_IN),
  .WRITEDATA_IN(WRITEDATA_IN), .BYTEENABLE_IN(BYTEENABLE_IN),
  .WAITREQUEST_OUT(WAITREQUEST_OUT), .PWM_LEVEL_OUT(PWM_LEVEL_OUT),
  .PWM_OE_N_OUT(PWM_OE_N_OUT), .PWM_OWN_OUT(PWM_OWN_OUT));

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [31:0] hi [4];
  logic wreq;
  logic shoot;
  logic sh;
  logic [3:0] lvl;
  logic [3:0] oe_n;
  logic [3:0] own;
  logic [3:0] pin;
  logic [31:0] rst_exp [9] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h1, 32'hF, 32'h0, 32'h0, 32'h0};
  int err_total = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  epw_top dut_u (.REF_CLK_IN(clk), .RESET_IN(rst), .ADDRESS_IN(addr), .READ_IN(rd_en),
    .WRITE_IN(wr_en), .WRITEDATA_IN(wdata), .BYTEENABLE_IN(be), .READDATA_OUT(rdata),
    .WAITREQUEST_OUT(wreq), .PWM_LEVEL_OUT(lvl), .PWM_OE_N_OUT(oe_n), .PWM_OWN_OUT(own));
  epw_bridge_model far_u (.level_in(lvl), .oe_n_in(oe_n), .pin_out(pin), .shoot_out(shoot));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    rv = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  // High cycles per pin over one 16-clock period, counts packed D..A
  task automatic meas(input logic [31:0] e);
    repeat (48) @(posedge clk);
    hi = '{default: 32'h0};
    repeat (16) begin
      @(posedge clk);
      sh = sh | shoot;
      for (int i = 0; i < 4; i++) hi[i] += {31'h0, pin[i]};
    end
    for (int i = 0; i < 4; i++) chk(hi[i], {24'h0, e[8*i+:8]});
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    sh = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rv, rst_exp[i]);
    end
    be <= 4'hE;
    bus(1'b1, 8'h08, 32'h3);
    be <= 4'hF;
    bus(1'b0, 8'h08, 32'h0);
    chk(rv, 32'hFF);
    // Period 16 clocks, duty 6 clocks
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h10, 32'hA);
    bus(1'b1, 8'h00, 32'h2C);
    repeat (8) begin
      @(posedge clk);
      chk({28'h0, lvl}, 32'h0);
    end
    meas(32'h06000600);
    chk({28'h0, oe_n}, 32'h5);
    bus(1'b1, 8'h00, 32'h2F);
    meas(32'h0A000A00);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'h0C);
    meas(32'h0);
    bus(1'b1, 8'h04, 32'hFF);
    bus(1'b1, 8'h00, 32'h3C);
    meas(32'h10001000);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h10, 32'hF);
    bus(1'b1, 8'h00, 32'h2C);
    meas(32'h06060606);
    // Rise delayed 4 clocks, fall not delayed
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b1, 8'h00, 32'hAC);
    sh = 1'b0;
    meas(32'h00000602);
    bus(1'b1, 8'h0C, 32'h2);
    meas(32'h00000200);
    bus(1'b1, 8'h0C, 32'h0);
    meas(32'h00000A06);
    chk({31'h0, sh}, 32'h0);
    bus(1'b1, 8'h00, 32'h6C);
    meas(32'h06000010);
    bus(1'b1, 8'h00, 32'hEC);
    meas(32'h00100600);
    bus(1'b1, 8'h00, 32'hEF);
    meas(32'h10000A10);
    bus(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk);
    chk({24'h0, own, oe_n}, 32'h0F);
    bus(1'b1, 8'h14, 32'hF);
    // Full forward from off: the always-active pin must wait for a new period
    bus(1'b1, 8'h00, 32'h6C);
    repeat (12) begin
      @(posedge clk);
      chk({28'h0, lvl}, 32'h0);
    end
    meas(32'h0);
    chk({24'h0, own, oe_n}, 32'hFF);
    results();
  end
endmodule
